/* rtl/can_err_inj_defs.svh */
// constants of the can error injector: offsets, fields, reset values, counts
// Function
// [RQ1] fire means six consecutive dominant bus bits
// [RQ2] single shot hits first frame after arming
// [RQ3] received and own transmitted frames both hit
// [RQ4] burst starts exactly at configured position; the code fires only at positions after the last identifier bit
// [RQ5] position counter includes stuff bits
// [RQ6] repeat mode targets only matching identifier
// [RQ7] repeat mode passes ignore count first
// [RQ8] repeat mode destroys count, keeps repeating
// [RQ9] disable stops; start only after apply
// [RQ10] other nodes flag the burst as error
// [RQ11] after destroy count, reload ignore count
`ifndef CAN_ERR_INJ_DEFS_SVH
`define CAN_ERR_INJ_DEFS_SVH
// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CEI_OFF_CTRL     8'h00
`define CEI_OFF_CAN_ID   8'h04
`define CEI_OFF_BIT_POS  8'h08
`define CEI_OFF_IGNORE   8'h0c
`define CEI_OFF_DESTROY  8'h10
`define CEI_OFF_STATUS   8'h14
// ****************************************************************
// field positions
// ****************************************************************
`define CEI_CTRL_ARM     0
`define CEI_CTRL_REP_EN  1
`define CEI_CTRL_APPLY   2
`define CEI_ST_ARMED     0
`define CEI_ST_REP_ACT   1
`define CEI_ST_IN_FRAME  2
`define CEI_ST_FORCING   3
`define CEI_ST_CNT_LSB   16
// ****************************************************************
// reset values
// ****************************************************************
`define CEI_RST_CAN_ID   11'h000
`define CEI_RST_BIT_POS  8'h00
`define CEI_RST_COUNT    8'h00
// ****************************************************************
// protocol counts
// ****************************************************************
`define CEI_ID_BITS      4'hb
`define CEI_STUFF_RUN    3'h5
`define CEI_DOM_BURST    3'h6
`define CEI_EOF_RUN      3'h7
`endif

/* rtl/can_err_inj_pkg.sv */
// types of the can error injector
package can_err_inj_pkg;
  // frame engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FRAME,
    ST_FORCE
  } eng_state_e;
endpackage

/* rtl/can_error_injector.sv */
// can error injector: wishbone registers, bus bit tracker and dominant burst
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "can_err_inj_defs.svh"
module can_error_injector #(
  parameter int POS_W = 8,                       // width of bit position
  parameter int CNT_W = 8                        // width of ignore/destroy counts
) (
  input  wire logic        clk_i,                // system clock
  input  wire logic        rst_i,                // synchronous reset, high
  input  wire logic [7:0]  wb_adr_i,             // wishbone byte address
  input  wire logic [31:0] wb_dat_i,             // wishbone write data
  input  wire logic [3:0]  wb_sel_i,             // wishbone byte enables
  input  wire logic        wb_we_i,              // wishbone write
  input  wire logic        wb_cyc_i,             // wishbone cycle
  input  wire logic        wb_stb_i,             // wishbone strobe
  output logic      [31:0] wb_dat_o,             // wishbone read data
  output logic             wb_ack_o,             // wishbone acknowledge
  input  wire logic        can_rx_i,             // bus level pin, 0 = dominant
  input  wire logic        bit_tick_i,           // one pulse per bus bit at sample point
  output logic             force_dom_o           // high forces transmitter dominant
);
  // ****************************************************************
  // bus slave and configuration
  // ****************************************************************
  logic [31:0]      rdata;                       // read data register
  logic             ack;                         // acknowledge register
  logic [10:0]      cfg_id;                      // identifier for repeat mode
  logic [POS_W-1:0] cfg_pos;                     // injection bit position
  logic [CNT_W-1:0] cfg_ign;                     // frames to let pass
  logic [CNT_W-1:0] cfg_des;                     // frames to destroy
  logic             cfg_rep_en;                  // repeat mode enable
  logic             arm_pls;                     // single shot arm pulse
  logic             apply_pls;                   // apply pulse
  logic [31:0]      next_rdata;
  logic             next_ack;
  logic [10:0]      next_cfg_id;
  logic [POS_W-1:0] next_cfg_pos;
  logic [CNT_W-1:0] next_cfg_ign;
  logic [CNT_W-1:0] next_cfg_des;
  logic             next_cfg_rep_en;
  logic             next_arm_pls;
  logic             next_apply_pls;
  logic [31:0]      wmask;                       // byte enables as bit mask
  logic [31:0]      status;                      // status word
  // engine state read by the bus
  logic             armed;
  logic             rep_act;
  logic             forcing;
  logic [15:0]      kill_cnt;
  can_err_inj_pkg::eng_state_e state;

  // byte lanes expand to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // status word from engine state
  always_comb begin
    status                            = 32'h0000_0000;
    status[`CEI_ST_ARMED]             = armed;
    status[`CEI_ST_REP_ACT]           = rep_act;
    status[`CEI_ST_IN_FRAME]          = (state != can_err_inj_pkg::ST_IDLE);
    status[`CEI_ST_FORCING]           = forcing;
    status[`CEI_ST_CNT_LSB +: 16]     = kill_cnt;
  end

  // decode, ack one cycle after request, write on the acked edge
  always_comb begin
    next_rdata      = rdata;
    next_ack        = wb_cyc_i && wb_stb_i && !ack;
    next_cfg_id     = cfg_id;
    next_cfg_pos    = cfg_pos;
    next_cfg_ign    = cfg_ign;
    next_cfg_des    = cfg_des;
    next_cfg_rep_en = cfg_rep_en;
    next_arm_pls    = 1'b0;
    next_apply_pls  = 1'b0;
    if (wb_cyc_i && wb_stb_i && !ack) begin      // read data captured while ack rises
      case (wb_adr_i)
        `CEI_OFF_CTRL:    next_rdata = {30'h0000_0000, cfg_rep_en, armed};
        `CEI_OFF_CAN_ID:  next_rdata = {21'h00_0000, cfg_id};
        `CEI_OFF_BIT_POS: next_rdata = 32'(cfg_pos);
        `CEI_OFF_IGNORE:  next_rdata = 32'(cfg_ign);
        `CEI_OFF_DESTROY: next_rdata = 32'(cfg_des);
        `CEI_OFF_STATUS:  next_rdata = status;
        default:          next_rdata = 32'h0000_0000;  // unmapped reads zero, still acked
      endcase
    end
    if (wb_cyc_i && wb_stb_i && ack && wb_we_i) begin
      case (wb_adr_i)
        `CEI_OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            next_cfg_rep_en = wb_dat_i[`CEI_CTRL_REP_EN];
            next_arm_pls    = wb_dat_i[`CEI_CTRL_ARM];
            next_apply_pls  = wb_dat_i[`CEI_CTRL_APPLY];
          end
        end
        `CEI_OFF_CAN_ID:  next_cfg_id  = (cfg_id & ~wmask[10:0]) | (wb_dat_i[10:0] & wmask[10:0]);
        `CEI_OFF_BIT_POS: next_cfg_pos = (cfg_pos & ~wmask[POS_W-1:0]) | (wb_dat_i[POS_W-1:0] & wmask[POS_W-1:0]);
        `CEI_OFF_IGNORE:  next_cfg_ign = (cfg_ign & ~wmask[CNT_W-1:0]) | (wb_dat_i[CNT_W-1:0] & wmask[CNT_W-1:0]);
        `CEI_OFF_DESTROY: next_cfg_des = (cfg_des & ~wmask[CNT_W-1:0]) | (wb_dat_i[CNT_W-1:0] & wmask[CNT_W-1:0]);
        default:          next_cfg_id  = cfg_id;   // unmapped writes ignored
      endcase
    end
  end

  // bus and configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata      <= 32'h0000_0000;
      ack        <= 1'b0;
      cfg_id     <= `CEI_RST_CAN_ID;
      cfg_pos    <= POS_W'(`CEI_RST_BIT_POS);
      cfg_ign    <= CNT_W'(`CEI_RST_COUNT);
      cfg_des    <= CNT_W'(`CEI_RST_COUNT);
      cfg_rep_en <= 1'b0;
      arm_pls    <= 1'b0;
      apply_pls  <= 1'b0;
    end else begin
      rdata      <= next_rdata;
      ack        <= next_ack;
      cfg_id     <= next_cfg_id;
      cfg_pos    <= next_cfg_pos;
      cfg_ign    <= next_cfg_ign;
      cfg_des    <= next_cfg_des;
      cfg_rep_en <= next_cfg_rep_en;
      arm_pls    <= next_arm_pls;
      apply_pls  <= next_apply_pls;
    end
  end
  assign wb_dat_o = rdata;
  assign wb_ack_o = ack;

  // ****************************************************************
  // pin synchroniser: three stages, change taken when stages two and three agree
  // ****************************************************************
  logic [2:0] rx_sync;                           // stage 0 read only by stage 1
  logic       rx_lvl;                            // filtered bus level
  logic [2:0] next_rx_sync;
  logic       next_rx_lvl;

  // shift and filter
  always_comb begin
    next_rx_sync = {rx_sync[1:0], can_rx_i};
    next_rx_lvl  = (rx_sync[1] == rx_sync[2]) ? rx_sync[2] : rx_lvl;
  end

  // synchroniser registers, idle bus is recessive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sync <= 3'h7;
      rx_lvl  <= 1'b1;
    end else begin
      rx_sync <= next_rx_sync;
      rx_lvl  <= next_rx_lvl;
    end
  end

  // ****************************************************************
  // frame engine
  // ****************************************************************
  logic [POS_W-1:0] raw_cnt;                     // bus bits since sof, stuff included
  logic [3:0]       dat_cnt;                     // destuffed bits after sof
  logic [2:0]       run;                         // equal-level run for destuffing
  logic             last;                        // previous bus level
  logic [2:0]       rec_run;                     // recessive run for frame end
  logic [10:0]      id_sr;                       // identifier shift register
  logic             id_done;                     // identifier fully seen
  logic             tgt;                         // this frame is to be destroyed
  logic [2:0]       burst;                       // dominant bits forced so far
  logic [CNT_W-1:0] ign_left;                    // frames still to pass
  logic [CNT_W-1:0] des_left;                    // frames still to destroy
  can_err_inj_pkg::eng_state_e next_state;
  logic [POS_W-1:0] next_raw_cnt;
  logic [3:0]       next_dat_cnt;
  logic [2:0]       next_run;
  logic             next_last;
  logic [2:0]       next_rec_run;
  logic [10:0]      next_id_sr;
  logic             next_id_done;
  logic             next_tgt;
  logic [2:0]       next_burst;
  logic [CNT_W-1:0] next_ign_left;
  logic [CNT_W-1:0] next_des_left;
  logic             next_armed;
  logic             next_rep_act;
  logic             next_forcing;
  logic [15:0]      next_kill_cnt;

  // bit tracking, target decision and burst generation
  always_comb begin
    next_state    = state;
    next_raw_cnt  = raw_cnt;
    next_dat_cnt  = dat_cnt;
    next_run      = run;
    next_last     = last;
    next_rec_run  = rec_run;
    next_id_sr    = id_sr;
    next_id_done  = id_done;
    next_tgt      = tgt;
    next_burst    = burst;
    next_ign_left = ign_left;
    next_des_left = des_left;
    next_armed    = armed;
    next_rep_act  = rep_act;
    next_forcing  = forcing;
    next_kill_cnt = kill_cnt;
    // repeat mode runs only after apply, stops at once on disable
    if (!cfg_rep_en) begin
      next_rep_act = 1'b0;                                   // [RQ9]
    end else if (apply_pls) begin
      next_rep_act  = 1'b1;                                  // [RQ9]
      next_ign_left = cfg_ign;
      next_des_left = cfg_des;
    end
    if (bit_tick_i) begin
      next_rec_run = rx_lvl ? ((rec_run == `CEI_EOF_RUN) ? rec_run : rec_run + 3'h1) : 3'h0;
      case (state)
        can_err_inj_pkg::ST_IDLE: begin
          // sof on the line, whoever sends it: bus or own channel
          if (!rx_lvl) begin                                 // [RQ3]
            next_state   = can_err_inj_pkg::ST_FRAME;
            next_raw_cnt = '0;
            next_dat_cnt = 4'h0;
            next_run     = 3'h1;
            next_last    = 1'b0;
            next_id_done = 1'b0;
            next_tgt     = armed;                            // [RQ2]
            next_armed   = 1'b0;                             // [RQ2]
          end
        end
        can_err_inj_pkg::ST_FRAME: begin
          next_raw_cnt = raw_cnt + POS_W'(1);                // [RQ5]
          next_last    = rx_lvl;
          if (run == `CEI_STUFF_RUN) begin
            next_run = 3'h1;                                 // stuff bit, no data
          end else begin
            next_run = (rx_lvl == last) ? run + 3'h1 : 3'h1;
            if (!id_done) begin
              next_dat_cnt = dat_cnt + 4'h1;
              next_id_sr   = {id_sr[9:0], rx_lvl};
              if (next_dat_cnt == `CEI_ID_BITS) begin
                next_id_done = 1'b1;
                // repeat mode: matching frames pass, then get destroyed
                if (rep_act && cfg_rep_en && next_id_sr == cfg_id) begin  // [RQ6] [RQ9]
                  if (ign_left != '0) begin
                    next_ign_left = ign_left - CNT_W'(1);    // [RQ7]
                  end else if (des_left != '0) begin
                    next_tgt = 1'b1;                         // [RQ8]
                    if (des_left == CNT_W'(1)) begin
                      next_ign_left = cfg_ign;               // [RQ11]
                      next_des_left = cfg_des;               // [RQ11]
                    end else begin
                      next_des_left = des_left - CNT_W'(1);  // [RQ8]
                    end
                  end
                end
              end
            end
          end
          // start forcing so the line is dominant from bit cfg_pos on
          if (next_tgt && next_id_done && next_raw_cnt == cfg_pos - POS_W'(1)) begin  // [RQ4]
            next_state   = can_err_inj_pkg::ST_FORCE;
            next_forcing = 1'b1;                             // [RQ1]
            next_burst   = 3'h0;
            next_tgt     = 1'b0;
          end else if (next_rec_run == `CEI_EOF_RUN) begin
            next_state = can_err_inj_pkg::ST_IDLE;           // frame or error frame over
            next_tgt   = 1'b0;
          end
        end
        can_err_inj_pkg::ST_FORCE: begin
          next_raw_cnt = raw_cnt + POS_W'(1);
          next_burst   = burst + 3'h1;
          if (next_burst == `CEI_DOM_BURST) begin            // [RQ1] six bits, then error frame runs out
            next_forcing  = 1'b0;
            next_state    = can_err_inj_pkg::ST_FRAME;
            next_id_done  = 1'b1;
            next_rec_run  = 3'h0;
            next_kill_cnt = kill_cnt + 16'h0001;
          end
        end
        default: begin
          next_state   = can_err_inj_pkg::ST_IDLE;
          next_forcing = 1'b0;
        end
      endcase
    end
    // arming wins over the clear at sof
    if (arm_pls) begin
      next_armed = 1'b1;                                     // [RQ2]
    end
  end

  // engine registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= can_err_inj_pkg::ST_IDLE;
      raw_cnt  <= '0;
      dat_cnt  <= 4'h0;
      run      <= 3'h0;
      last     <= 1'b1;
      rec_run  <= 3'h0;
      id_sr    <= 11'h000;
      id_done  <= 1'b0;
      tgt      <= 1'b0;
      burst    <= 3'h0;
      ign_left <= '0;
      des_left <= '0;
      armed    <= 1'b0;
      rep_act  <= 1'b0;
      forcing  <= 1'b0;
      kill_cnt <= 16'h0000;
    end else begin
      state    <= next_state;
      raw_cnt  <= next_raw_cnt;
      dat_cnt  <= next_dat_cnt;
      run      <= next_run;
      last     <= next_last;
      rec_run  <= next_rec_run;
      id_sr    <= next_id_sr;
      id_done  <= next_id_done;
      tgt      <= next_tgt;
      burst    <= next_burst;
      ign_left <= next_ign_left;
      des_left <= next_des_left;
      armed    <= next_armed;
      rep_act  <= next_rep_act;
      forcing  <= next_forcing;
      kill_cnt <= next_kill_cnt;
    end
  end

  assign force_dom_o = forcing;                              // [RQ10] nodes see the burst as a stuff error

endmodule // can_error_injector

/* dv/can_err_inj_props.sv */
// port checker of the can error injector
`timescale 1ns/1ps
module can_err_inj_props (
  input wire logic        clk_i,       // system clock
  input wire logic        rst_i,       // synchronous reset
  input wire logic [7:0]  wb_adr_i,    // bus address
  input wire logic        wb_we_i,     // bus write
  input wire logic        wb_cyc_i,    // bus cycle
  input wire logic        wb_stb_i,    // bus strobe
  input wire logic [31:0] wb_dat_o,    // read data
  input wire logic        wb_ack_o,    // acknowledge
  input wire logic        bit_tick_i,  // bus bit tick
  input wire logic        force_dom_o  // dominant force
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] ftick;       // ticks seen inside a burst
  logic [3:0] since_tick;  // cycles since the last tick
  logic [3:0] next_ftick;
  logic [3:0] next_since;
  // ****************************************************************
  // helper counters
  // ****************************************************************
  always_comb begin
    next_ftick = force_dom_o ? ftick + {3'h0, bit_tick_i} : 4'h0;
    next_since = bit_tick_i ? 4'h0 : (since_tick == 4'hf ? since_tick : since_tick + 4'h1);
  end
  always_ff @(posedge clk_i) begin
    ftick      <= rst_i ? 4'h0 : next_ftick;
    since_tick <= rst_i ? 4'hf : next_since;
  end
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence burst_end;
    $fell(force_dom_o);
  endsequence
  // ****************************************************************
  // properties
  // ****************************************************************
  ack_follows_a: assert property (bus_req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  reset_quiet_a: assert property ($fell(rst_i) |-> !force_dom_o && !wb_ack_o && wb_dat_o == 32'h0)
    else $error("outputs not quiet after reset");
  unmapped_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h14) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  burst_six_a: assert property (burst_end |-> ftick == 4'h6)
    else $error("burst not six bits long");
  burst_cap_a: assert property (force_dom_o |-> ftick <= 4'h6)
    else $error("burst exceeds six bits");
  burst_on_tick_a: assert property ($changed(force_dom_o) |-> since_tick <= 4'h3)
    else $error("burst edge away from a bit boundary");
endmodule // can_err_inj_props

/* dv/can_node_model.sv */
// behavioural bus node sending frames past the injector
`timescale 1ns/1ps
module can_node_model (
  input  wire logic        clk_i,        // system clock
  input  wire logic        start_i,      // begin one frame
  input  wire logic [10:0] id_i,         // frame identifier
  input  wire logic        force_dom_i,  // injector burst
  output logic             can_rx_o,     // resolved bus level
  output logic             bit_tick_o,   // sample point pulse
  output logic             busy_o,       // frame in progress
  output logic       [7:0] hit_pos_o,    // raw index of first forced bit
  output logic       [3:0] hit_len_o     // forced bits seen
);
  logic tx = 1'b1;  // own driven level, recessive when idle
  logic err;        // bit error seen
  int   raw;        // raw bit index, stuff bits included
  // wired-and bus: recessive unless pulled dominant
  assign can_rx_o = tx & ~force_dom_i;
  // one bit of eight cycles, tick sampled at the sixth edge
  task send_bit(input logic b);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      if (k == 0) tx <= b;
      bit_tick_o <= (k == 4);
      if (k == 5) begin
        if (force_dom_i) begin
          if (hit_len_o == 4'h0) hit_pos_o <= raw[7:0];
          hit_len_o <= hit_len_o + 4'h1;
        end
        if (b && !can_rx_o) err = 1'b1;
        raw++;
      end
    end
  endtask
  // frames look alike whether received or sent by the own channel
  task send_frame(input logic [10:0] i);
    logic [27:0] v;
    logic        last;
    int          run;
    v = {1'b0, i, 16'h0000};
    raw = 0;
    err = 1'b0;
    run = 0;
    last = 1'b1;
    for (int n = 27; n >= 0 && !err; n--) begin
      send_bit(v[n]);
      run = (v[n] == last) ? run + 1 : 1;
      last = v[n];
      if (run == 5 && !err) begin
        send_bit(~last);
        last = ~last;
        run = 1;
      end
    end
    repeat (14) send_bit(1'b1); // error stops the frame, then idle
  endtask
  initial begin
    bit_tick_o = 1'b0;
    busy_o = 1'b0;
    hit_pos_o = 8'hff;
    hit_len_o = 4'h0;
    forever begin
      @(posedge clk_i);
      if (start_i) begin
        busy_o <= 1'b1;
        hit_len_o <= 4'h0;
        hit_pos_o <= 8'hff;
        send_frame(id_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule // can_node_model

/* dv/testbench.sv */
// self-checking bench of the can error injector
`timescale 1ns/1ps
`include "can_err_inj_defs.svh"
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, start = 1'b0;
  logic [10:0] id = 11'h000;
  logic [31:0] rdat;
  logic        ack, rx, tick, fdom, busy;
  logic [7:0]  hpos;
  logic [3:0]  hlen;
  int          mismatches = 0;
  int          tests_run = 0;
  always #2 clk_i = ~clk_i;
  can_error_injector can_error_injector_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .can_rx_i(rx), .bit_tick_i(tick), .force_dom_o(fdom));
  can_node_model can_node_model_inst (.clk_i(clk_i), .start_i(start), .id_i(id), .force_dom_i(fdom),
    .can_rx_o(rx), .bit_tick_o(tick), .busy_o(busy), .hit_pos_o(hpos), .hit_len_o(hlen));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one classic bus cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 50) begin mismatches++; complete_run; end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask
  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    check(what, q & m, exp);
  endtask
  // one frame on the bus, then judge the burst it saw
  task frame(input logic [10:0] i, input logic [3:0] len, input logic [7:0] pos);
    int n;
    @(posedge clk_i);
    start <= 1'b1; id <= i;
    @(posedge clk_i);
    start <= 1'b0;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk_i);
      if (busy === 1'b0) break;
    end
    if (n == 3000) begin mismatches++; complete_run; end
    check("burst length", {28'h0, hlen}, {28'h0, len});
    if (len != 4'h0) check("burst position", {24'h0, hpos}, {24'h0, pos});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task sc_reset;
    for (int a = 0; a <= 32; a += 4) rd_chk("reset value", a[7:0], 32'hffffffff, 32'h0);
  endtask
  task sc_single;
    logic [31:0] q;
    wr(`CEI_OFF_BIT_POS, 32'h14);
    wb(1'b1, `CEI_OFF_CTRL, 32'h1, 4'h0, q);
    rd_chk("arm without byte enable", `CEI_OFF_STATUS, 32'h1, 32'h0);
    frame(11'h000, 4'h0, 8'h00);
    wr(`CEI_OFF_CTRL, 32'h1);
    rd_chk("armed", `CEI_OFF_STATUS, 32'h1, 32'h1);
    frame(11'h000, 4'h6, 8'h14);
    rd_chk("arm spent", `CEI_OFF_STATUS, 32'h1, 32'h0);
    frame(11'h000, 4'h0, 8'h00);
    wr(`CEI_OFF_BIT_POS, 32'h8);
    wr(`CEI_OFF_CTRL, 32'h1);
    frame(11'h2a5, 4'h0, 8'h00);
    rd_chk("destroyed count", `CEI_OFF_STATUS, 32'hffff0000, 32'h00010000);
  endtask
  task sc_repeat;
    logic [10:0] ids [6];
    logic [3:0]  lens [6];
    logic [31:0] q;
    ids = '{11'h2a5, 11'h155, 11'h2a5, 11'h2a5, 11'h2a5, 11'h2a5};
    lens = '{4'h0, 4'h0, 4'h6, 4'h6, 4'h0, 4'h6};
    wr(`CEI_OFF_CAN_ID, 32'h2a5);
    wb(1'b1, `CEI_OFF_CAN_ID, 32'h0, 4'h1, q);
    rd_chk("id low lane only", `CEI_OFF_CAN_ID, 32'hffffffff, 32'h200);
    wr(`CEI_OFF_CAN_ID, 32'h2a5);
    wr(`CEI_OFF_BIT_POS, 32'h10);
    wr(`CEI_OFF_IGNORE, 32'h1);
    wr(`CEI_OFF_DESTROY, 32'h2);
    rd_chk("ignore count", `CEI_OFF_IGNORE, 32'hffffffff, 32'h1);
    rd_chk("destroy count", `CEI_OFF_DESTROY, 32'hffffffff, 32'h2);
    rd_chk("bit position", `CEI_OFF_BIT_POS, 32'hffffffff, 32'h10);
    wr(`CEI_OFF_CTRL, 32'h2);
    frame(11'h2a5, 4'h0, 8'h00);
    wr(`CEI_OFF_CTRL, 32'h6);
    rd_chk("repeat enable", `CEI_OFF_CTRL, 32'h7, 32'h2);
    rd_chk("repeat active", `CEI_OFF_STATUS, 32'h2, 32'h2);
    for (int n = 0; n < 6; n++) frame(ids[n], lens[n], 8'h10);
    wr(`CEI_OFF_CTRL, 32'h0);
    rd_chk("repeat stopped", `CEI_OFF_STATUS, 32'h2, 32'h0);
    frame(11'h2a5, 4'h0, 8'h00);
    rd_chk("destroyed count", `CEI_OFF_STATUS, 32'hffff0000, 32'h00040000);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_reset;
    sc_single;
    sc_repeat;
    complete_run;
  end
endmodule // testbench
bind can_error_injector can_err_inj_props can_err_inj_props_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .bit_tick_i(bit_tick_i), .force_dom_o(force_dom_o));
